// *** bench/sbcwd_ctrl_properties.sv ***
// Concurrent checks on the serial control, reset and watchdog block
module sbcwd_props (
  input wire clk,
  input wire rst_n,
  input wire select_low_input,
  input wire vint_undervoltage,
  input wire vcc_below_reset_threshold,
  input wire serial_out_oe,
  input wire reset_out_n,
  input wire [15:0] control_word,
  input wire [1:0] op_mode,
  input wire internal_supply_fail_flag,
  input wire wd_reset_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [7:0] sel_hi_ff;
  reg [10:0] ok_ff;
  // Cycles since select went high and since supply recovered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_hi_ff <= 8'h00;
      ok_ff <= 11'h000;
    end else begin
      sel_hi_ff <= !select_low_input ? 8'h00 : sel_hi_ff + {7'h00, sel_hi_ff != 8'hff};
      ok_ff <= vcc_below_reset_threshold ? 11'h000 : ok_ff + {10'h000, ok_ff != 11'h7ff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Supply low well past the filter time
  sequence vcc_low_long;
    vcc_below_reset_threshold[*8] ##1 vcc_below_reset_threshold[*8] ##1
      vcc_below_reset_threshold[*4];
  endsequence
  // Frame end while in active mode
  sequence sel_end_active;
    $rose(select_low_input) && op_mode == 2'h1;
  endsequence
  AST_RST_FILT: assert property (vcc_low_long |-> !reset_out_n)
    else $error("reset not driven low on long supply drop");
  AST_RST_REL: assert property ($rose(reset_out_n) |-> ok_ff >= 11'd256)
    else $error("reset released before the delay");
  AST_SEL_OE: assert property (sel_end_active |-> ##[1:6] !serial_out_oe)
    else $error("output line not released after select rise");
  AST_CTRL_TAKE: assert property (($changed(control_word) && !vint_undervoltage &&
      !$past(vint_undervoltage)) |-> sel_hi_ff >= 8'd1 && sel_hi_ff <= 8'd10)
    else $error("control word changed away from a frame end");
  AST_VINT: assert property (vint_undervoltage |-> ##[1:4]
      (control_word == 16'h0000 && !internal_supply_fail_flag))
    else $error("undervoltage did not clear settings and flag");
  AST_FAIL_STAY: assert property ($fell(internal_supply_fail_flag) |=>
      !internal_supply_fail_flag [*8])
    else $error("fail flag came back");
  AST_WD_FAIL: assert property ($rose(wd_reset_flag) |-> ##[0:3]
      (!reset_out_n && op_mode == 2'h0))
    else $error("watchdog flag without reset and standby");
  AST_WD_CLR: assert property ($fell(wd_reset_flag) |->
      sel_hi_ff >= 8'd1 && sel_hi_ff <= 8'd10)
    else $error("watchdog flag cleared without serial access");
endmodule

bind sbcwd_ctrl sbcwd_props sbcwd_props_i (
  .clk(clk),
  .rst_n(rst_n),
  .select_low_input(select_low_input),
  .vint_undervoltage(vint_undervoltage),
  .vcc_below_reset_threshold(vcc_below_reset_threshold),
  .serial_out_oe(serial_out_oe),
  .reset_out_n(reset_out_n),
  .control_word(control_word),
  .op_mode(op_mode),
  .internal_supply_fail_flag(internal_supply_fail_flag),
  .wd_reset_flag(wd_reset_flag)
);

// *** bench/sbcwd_host.sv ***
// Host model driving the serial control link
module sbcwd_host (
  input wire clk,
  output logic select_low_input,
  output logic serial_clk,
  output logic serial_in_line,
  input wire serial_out,
  input wire serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_do;
  initial begin
    select_low_input = 1'b1;
    serial_clk = 1'b0;
    serial_in_line = 1'b0;
    last_do = 1'b0;
  end
  // One frame; a released line reads as the inverse of its last level
  task automatic xfer(input logic [31:0] data, input int nbits, output logic [15:0] diag);
    int i;
    diag = 16'h0000;
    @(negedge clk);
    select_low_input = 1'b0;
    #125.5;
    for (i = 0; i < nbits; i++) begin
      serial_in_line = data[i];
      #31;
      last_do = serial_out_oe ? serial_out : ~last_do;
      if (i < 16) diag[i] = last_do;
      serial_clk = 1'b1;
      #62;
      serial_clk = 1'b0;
      #32;
    end
    #125;
    select_low_input = 1'b1;
    #375;
  endtask
endmodule

// *** bench/test_sbcwd_ctrl.sv ***
// Self-checking bench for the serial control, reset and watchdog block
module test_sbcwd_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vint = 1'b0;
  logic vcc_low = 1'b0;
  logic wd_low = 1'b0;
  logic [4:0] mon = 5'h00;
  wire sel, sclk, di, sdo, oe, rst_out_n, fail, wdf;
  wire [15:0] ctrl;
  wire [1:0] mode;
  logic [15:0] diag;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int i, n;
  logic [31:0] r_data [5] = '{32'h0001, 32'h0002, 32'h0040, 32'h0003, 32'h0041_0003};
  int r_bits [5] = '{16, 8, 16, 17, 32};
  logic [15:0] r_ctrl [5] = '{16'h0001, 16'h0001, 16'h0040, 16'h0040, 16'h0041};
  logic r_b0 [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  always #2 clk = ~clk;
  sbcwd_host sbcwd_host_i (.clk(clk), .select_low_input(sel), .serial_clk(sclk),
    .serial_in_line(di),
    .serial_out(sdo), .serial_out_oe(oe));
  sbcwd_ctrl #(.LONG_OPEN_CYC(4096), .WD_BASE_CYC(2048)) sbcwd_ctrl_i (.clk(clk),
    .rst_n(rst_n), .select_low_input(sel), .serial_clk(sclk), .serial_in_line(di),
    .serial_out(sdo), .serial_out_oe(oe), .wake_monitor_input(mon), .vint_undervoltage(vint),
    .vcc_below_reset_threshold(vcc_low), .wd_current_low(wd_low), .reset_out_n(rst_out_n),
    .control_word(ctrl), .op_mode(mode), .internal_supply_fail_flag(fail),
    .wd_reset_flag(wdf));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycles until reset output is released, bounded
  task automatic wait_rel(output int k);
    k = 0;
    while (rst_out_n !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    check("rst_vals", {oe, rst_out_n, ctrl, mode, fail, wdf}, {20'h00000, 2'b10});
    wait_rel(n);
    check("rel_long", n >= 1020 && n <= 1040, 1);
    sbcwd_host_i.xfer(32'h0041, 16, diag);
    vint = 1'b1;
    repeat (4) @(negedge clk);
    vint = 1'b0;
    repeat (4) @(negedge clk);
    check("vint", {ctrl, mode, fail}, 19'h00000);
    // Ordinary frames, good and malformed
    for (i = 0; i < 5; i++) begin
      sbcwd_host_i.xfer(r_data[i], r_bits[i], diag);
      check("row_b0", diag[0], r_b0[i]);
      check("row_or", diag[1], r_b0[i] & r_data[i][1]);
      check("row_ctrl", ctrl, r_ctrl[i]);
      check("row_mode", mode, r_ctrl[i][1:0]);
    end
    // Trigger, service in the open window, then one too early
    sbcwd_host_i.xfer(32'h1041, 16, diag);
    repeat (600) @(negedge clk);
    sbcwd_host_i.xfer(32'h1041, 16, diag);
    check("wd_ok", {rst_out_n, wdf}, 2'b10);
    sbcwd_host_i.xfer(32'h1041, 16, diag);
    check("wd_fail", {rst_out_n, wdf, mode}, 4'b0100);
    wait_rel(n);
    check("rel_short", n > 100 && n < 256, 1);
    sbcwd_host_i.xfer(32'h0000, 16, diag);
    check("wd_diag", diag[1], 1'b1);
    check("wd_clr", wdf, 1'b0);
    // Wake from sleep through monitor zero
    sbcwd_host_i.xfer(32'h0080, 16, diag);
    repeat (300) @(negedge clk);
    sbcwd_host_i.xfer(32'h0083, 16, diag);
    check("sleep", mode, 2'h3);
    mon[1] = 1'b1;
    repeat (100) @(negedge clk);
    check("no_wake", oe, 1'b0);
    mon[0] = 1'b1;
    n = 0;
    while (!(oe === 1'b1 && sdo === 1'b0) && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("wake", n < 200, 1);
    repeat (50) @(negedge clk);
    check("hold", {oe, sdo}, 2'b10);
    sbcwd_host_i.xfer(32'h0080, 16, diag);
    check("held", diag, 16'h0000);
    check("freed", oe, 1'b0);
    sbcwd_host_i.xfer(32'h0080, 16, diag);
    check("src", diag[3:2], 2'b11);
    sbcwd_host_i.xfer(32'h0080, 16, diag);
    check("lvl", diag[3:2], 2'b10);
    // Short dip ignored, long dip resets
    vcc_low = 1'b1;
    repeat (10) @(negedge clk);
    vcc_low = 1'b0;
    repeat (5) @(negedge clk);
    check("dip", rst_out_n, 1'b1);
    vcc_low = 1'b1;
    repeat (40) @(negedge clk);
    check("uv", rst_out_n, 1'b0);
    vcc_low = 1'b0;
    wait_rel(n);
    check("rel_uv", n >= 1020 && n <= 1040, 1);
    // Stop mode: watchdog off only while load current is low
    wd_low = 1'b1;
    sbcwd_host_i.xfer(32'h0002, 16, diag);
    repeat (4300) @(negedge clk);
    check("stop_off", {rst_out_n, wdf}, 2'b10);
    wd_low = 1'b0;
    repeat (4300) @(negedge clk);
    check("stop_on", {rst_out_n, wdf, mode}, 4'b0100);
    end_sim();
  end
endmodule

// *** rtl/sbcwd_buf2.v ***
// Two-entry valid/ready buffer for received control words
module sbcwd_buf2 #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;

  // Full and empty from the fill count
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Pointers and count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage, read through the registered entry
  always @(posedge clk) begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end
endmodule

// *** rtl/sbcwd_ctrl.v ***
// Serial control link, reset generator, window watchdog and wake-up monitor
`include "sbcwd_defs.vh"

module sbcwd_ctrl #(
  parameter LONG_OPEN_CYC = `SBCWD_LONG_OPEN_CYC,
  parameter WD_BASE_CYC = `SBCWD_WD_BASE_CYC,
  parameter NUM_MON = `SBCWD_NUM_MON
) (
  input wire clk,
  input wire rst_n,
  input wire select_low_input,
  input wire serial_clk,
  input wire serial_in_line,
  output wire serial_out,
  output wire serial_out_oe,
  input wire [NUM_MON-1:0] wake_monitor_input,
  input wire vint_undervoltage,
  input wire vcc_below_reset_threshold,
  input wire wd_current_low,
  output wire reset_out_n,
  output wire [15:0] control_word,
  output wire [1:0] op_mode,
  output wire internal_supply_fail_flag,
  output wire wd_reset_flag
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam SW = 6 + NUM_MON;
  reg [SW-1:0] s1_ff;
  reg [SW-1:0] s2_ff;
  reg sclk_d_ff;
  reg sel_d_ff;
  wire sel_n;
  wire sclk;
  wire sdi;
  wire [NUM_MON-1:0] mon;
  wire vint_uv;
  wire vcc_low;
  wire wd_low_i;
  wire sclk_rise;
  wire sclk_fall;
  wire sel_fall;
  wire sel_rise;

  // Two flip-flops on every outside input
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= {{(SW-1){1'b0}}, 1'b1}; // Select idles high: no false frame start
      s2_ff <= {{(SW-1){1'b0}}, 1'b1};
      sclk_d_ff <= 1'b0;
      sel_d_ff <= 1'b1;
    end else begin
      s1_ff <= {wd_current_low, vcc_below_reset_threshold, vint_undervoltage,
                wake_monitor_input, serial_in_line, serial_clk, select_low_input};
      s2_ff <= s1_ff;
      sclk_d_ff <= sclk;
      sel_d_ff <= sel_n;
    end
  end

  assign sel_n = s2_ff[0];
  assign sclk = s2_ff[1];
  assign sdi = s2_ff[2];
  assign mon = s2_ff[3 +: NUM_MON];
  assign vint_uv = s2_ff[3 + NUM_MON];
  assign vcc_low = s2_ff[4 + NUM_MON];
  assign wd_low_i = s2_ff[5 + NUM_MON];
  assign sclk_rise = sclk & ~sclk_d_ff & ~sel_n;
  assign sclk_fall = ~sclk & sclk_d_ff & ~sel_n;
  assign sel_fall = ~sel_n & sel_d_ff;
  assign sel_rise = sel_n & ~sel_d_ff;

  // ----------------------------------------------------------------
  // Serial shift registers
  // ----------------------------------------------------------------
  reg [15:0] rx_ff;
  reg [15:0] tx_ff;
  reg [3:0] bit_cnt_ff;
  reg any_edge_ff;
  reg frame_err_ff;
  reg oe_ff;
  reg err_or_ff;
  reg wake_low_ff;
  reg src_pending_ff;
  reg [NUM_MON-1:0] src_ff;
  reg [15:0] ctrl_ff;
  reg [1:0] mode_ff;
  reg fail_ff;
  reg wdr_ff;
  wire [15:0] diag;
  wire frame_ok;
  wire buf_valid;
  wire buf_ready_in;
  wire [15:0] buf_word;
  wire [NUM_MON-1:0] mon_en;

  assign mon_en = ctrl_ff[`SBCWD_MON_EN_LSB +: NUM_MON];
  assign frame_ok = (bit_cnt_ff == 4'h0) & any_edge_ff;

  // Diagnosis word: source after monitor wake until a frame starts in standby mode, levels afterwards
  assign diag = {{(16 - 3 - NUM_MON){1'b0}},
                 (src_pending_ff ? src_ff : (mon & mon_en)),
                 src_pending_ff, wdr_ff, fail_ff};

  // Receive, transmit and framing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      bit_cnt_ff <= 4'h0;
      any_edge_ff <= 1'b0;
      frame_err_ff <= 1'b0;
      oe_ff <= 1'b0;
      err_or_ff <= 1'b0;
    end else if (sel_fall) begin
      tx_ff <= diag;
      err_or_ff <= frame_err_ff; // Whole frame signals the error
      bit_cnt_ff <= 4'h0;
      any_edge_ff <= 1'b0;
      oe_ff <= 1'b1;
    end else if (sel_rise) begin
      oe_ff <= 1'b0;
      frame_err_ff <= ~frame_ok;
    end else begin
      if (sclk_fall) begin
        rx_ff <= {sdi, rx_ff[15:1]};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        any_edge_ff <= 1'b1;
      end
      if (sclk_rise) begin
        tx_ff <= {1'b0, tx_ff[15:1]};
        frame_err_ff <= 1'b0;
      end
    end
  end

  // Output line: wake hold low, error flag high, else data
  // hold low after wake
  assign serial_out = wake_low_ff ? 1'b0 :
                      frame_err_ff ? 1'b1 :
                      err_or_ff ? (tx_ff[0] | sdi) : tx_ff[0];
  assign serial_out_oe = oe_ff | wake_low_ff;

  // Valid words pass the two-entry buffer before they take effect
  sbcwd_buf2 #(
    .WIDTH(16)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(sel_rise & frame_ok),
    .in_ready(buf_ready_in),
    .in_data(rx_ff),
    .out_valid(buf_valid),
    .out_ready(1'b1),
    .out_data(buf_word)
  );

  // ----------------------------------------------------------------
  // Control word, mode and flags
  // ----------------------------------------------------------------
  reg [1:0] nxt_mode;
  reg mode_chg_ff;
  reg wd_fail;
  wire trig;
  wire low_power;

  assign trig = buf_valid & buf_word[`SBCWD_WDP_WRITE_BIT];
  assign low_power = (mode_ff == `SBCWD_MODE_STOP) | (mode_ff == `SBCWD_MODE_SLEEP);

  always @* begin
    nxt_mode = mode_ff;
    if (wd_fail)
      nxt_mode = `SBCWD_MODE_STANDBY;
    else if (buf_valid)
      nxt_mode = buf_word[`SBCWD_MODE_LSB +: `SBCWD_MODE_W];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= `SBCWD_CTRL_RESET;
      mode_ff <= `SBCWD_MODE_STANDBY;
      mode_chg_ff <= 1'b0;
      fail_ff <= 1'b1;
      wdr_ff <= 1'b0;
    end else if (vint_uv) begin
      ctrl_ff <= `SBCWD_CTRL_RESET;
      mode_ff <= `SBCWD_MODE_STANDBY;
      mode_chg_ff <= 1'b0;
      fail_ff <= 1'b0;
      wdr_ff <= 1'b0;
    end else begin
      if (buf_valid)
        ctrl_ff <= buf_word;
      mode_ff <= nxt_mode;
      mode_chg_ff <= (nxt_mode != mode_ff);
      if (wd_fail)
        wdr_ff <= 1'b1;
      else if (sel_rise)
        wdr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset generator
  // ----------------------------------------------------------------
  reg [15:0] rst_cnt_ff;
  reg rst_out_ff;
  reg rst_rel_ff;
  wire [15:0] rel_cyc;

  localparam [15:0] REL_SHORT = `SBCWD_RST_SHORT_CYC;
  localparam [15:0] REL_LONG = `SBCWD_RST_LONG_CYC;
  assign rel_cyc = ctrl_ff[`SBCWD_SHORT_RST_BIT] ? REL_SHORT : REL_LONG;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_ff <= 16'h0000;
      rst_out_ff <= 1'b0;
      rst_rel_ff <= 1'b0;
    end else begin
      rst_rel_ff <= 1'b0;
      if (wd_fail) begin
        rst_out_ff <= 1'b0;
        rst_cnt_ff <= 16'h0000;
      end else if (rst_out_ff) begin
        if (!vcc_low)
          rst_cnt_ff <= 16'h0000;
        else if (rst_cnt_ff >= `SBCWD_FILT_CYC - 1) begin
          rst_out_ff <= 1'b0;
          rst_cnt_ff <= 16'h0000;
        end else
          rst_cnt_ff <= rst_cnt_ff + 16'h0001;
      end else begin
        if (vcc_low)
          rst_cnt_ff <= 16'h0000;
        else if (rst_cnt_ff >= rel_cyc - 16'h0001) begin
          rst_out_ff <= 1'b1;
          rst_rel_ff <= 1'b1;
          rst_cnt_ff <= 16'h0000;
        end else
          rst_cnt_ff <= rst_cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Window watchdog
  // ----------------------------------------------------------------
  localparam WD_LONG = 2'h0;
  localparam WD_CLOSED = 2'h1;
  localparam WD_OPEN = 2'h2;
  localparam WD_OFF = 2'h3;
  reg [1:0] wd_st_ff;
  reg [31:0] wd_cnt_ff;
  reg [2:0] wdp_ff;
  wire [31:0] half_cyc;
  wire wd_off_req;

  assign half_cyc = (WD_BASE_CYC << wdp_ff) >> 1;
  assign wd_off_req = low_power & ~ctrl_ff[`SBCWD_WD_STAY_BIT] &
                      ((mode_ff == `SBCWD_MODE_SLEEP) | wd_low_i);

  always @* begin
    wd_fail = 1'b0;
    case (wd_st_ff)
      WD_LONG: wd_fail = ~trig & (wd_cnt_ff >= LONG_OPEN_CYC - 1);
      WD_CLOSED: wd_fail = trig;
      WD_OPEN: wd_fail = ~trig & (wd_cnt_ff >= half_cyc - 32'h1);
      default: wd_fail = 1'b0;
    endcase
    if (!rst_out_ff)
      wd_fail = 1'b0;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_st_ff <= WD_LONG;
      wd_cnt_ff <= 32'h0;
      wdp_ff <= 3'h0;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 32'h1;
      if (trig)
        wdp_ff <= buf_word[`SBCWD_WDP_LSB +: `SBCWD_WDP_W];
      if (!rst_out_ff | rst_rel_ff | wd_fail | mode_chg_ff) begin
        wd_st_ff <= WD_LONG;
        wd_cnt_ff <= 32'h0;
      end else if (wd_off_req) begin
        wd_st_ff <= WD_OFF;
      end else begin
        case (wd_st_ff)
          WD_LONG, WD_OPEN: begin
            if (trig) begin
              wd_st_ff <= WD_CLOSED;
              wd_cnt_ff <= 32'h0;
            end
          end
          WD_CLOSED: begin
            if (wd_cnt_ff >= half_cyc - 32'h1) begin
              wd_st_ff <= WD_OPEN;
              wd_cnt_ff <= 32'h0;
            end
          end
          WD_OFF: begin
            // Off condition gone: restart with long open window
            wd_st_ff <= WD_LONG;
            wd_cnt_ff <= 32'h0;
          end
          default: wd_st_ff <= WD_LONG;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Wake-up monitor
  // ----------------------------------------------------------------
  reg [NUM_MON-1:0] ref_ff;
  wire [NUM_MON-1:0] mon_edge;
  wire enter_lp;

  assign enter_lp = ~low_power & ((nxt_mode == `SBCWD_MODE_STOP) |
                                  (nxt_mode == `SBCWD_MODE_SLEEP));
  assign mon_edge = (mon ^ ref_ff) & mon_en;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_ff <= {NUM_MON{1'b0}};
      src_ff <= {NUM_MON{1'b0}};
      src_pending_ff <= 1'b0;
      wake_low_ff <= 1'b0;
    end else begin
      if (enter_lp)
        ref_ff <= mon & mon_en;
      if (low_power & (|mon_edge)) begin
        src_ff <= mon_edge;
        src_pending_ff <= 1'b1;
      end else if (sel_fall & (mode_ff == `SBCWD_MODE_STANDBY)) begin
        src_pending_ff <= 1'b0;
      end
      if (buf_valid)
        wake_low_ff <= 1'b0;
      else if (low_power & (|mon_edge))
        wake_low_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reset_out_n = rst_out_ff;
  assign control_word = ctrl_ff;
  assign op_mode = mode_ff;
  assign internal_supply_fail_flag = fail_ff;
  assign wd_reset_flag = wdr_ff;
endmodule

// *** rtl/sbcwd_defs.vh ***
// Constants of the serial control, reset and watchdog block
`ifndef SBCWD_DEFS_VH
`define SBCWD_DEFS_VH
// ----------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------
`define SBCWD_WORD_W 16
`define SBCWD_MODE_LSB 0
`define SBCWD_MODE_W 2
`define SBCWD_WDP_LSB 2
`define SBCWD_WDP_W 3
`define SBCWD_WD_STAY_BIT 5
`define SBCWD_SHORT_RST_BIT 6
`define SBCWD_MON_EN_LSB 7
`define SBCWD_NUM_MON 5
`define SBCWD_WDP_WRITE_BIT 12
`define SBCWD_CTRL_RESET 16'h0000
// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define SBCWD_MODE_STANDBY 2'h0
`define SBCWD_MODE_ACTIVE 2'h1
`define SBCWD_MODE_STOP 2'h2
`define SBCWD_MODE_SLEEP 2'h3
// ----------------------------------------------------------------
// Diagnosis word layout
// ----------------------------------------------------------------
`define SBCWD_DIAG_FAIL_BIT 0
`define SBCWD_DIAG_WDR_BIT 1
`define SBCWD_DIAG_SRC_BIT 2
`define SBCWD_DIAG_MON_LSB 3
// ----------------------------------------------------------------
// Timing, in internal oscillator cycles
// ----------------------------------------------------------------
`define SBCWD_FILT_CYC 16
`define SBCWD_RST_LONG_CYC 1024
`define SBCWD_RST_SHORT_CYC 256
`define SBCWD_LONG_OPEN_CYC 65536
`define SBCWD_WD_BASE_CYC 2048
`endif
